/* hw/alc_lookup_cam.sv */
// Address lookup table with header address capture and a buffered word path.
module alc_lookup_cam
  import alc_pkg::*;
#(
  parameter int table_slot_count = ALC_SLOTS,
  parameter int FIFO_DEPTH = ALC_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Write request
  input wire logic wr_req,
  input wire logic [ALC_HW_W-1:0] wr_hw_address,
  input wire logic [ALC_NET_W-1:0] wr_network_address,
  output logic wr_done,
  output logic wr_ok,
  // Clear request
  input wire logic clr_req,
  input wire logic [ALC_NET_W-1:0] removal_key,
  output logic clr_done,
  output logic clr_ok,
  // Lookup request
  input wire logic lk_req,
  input wire logic [ALC_NET_W-1:0] lookup_key,
  output logic lk_done,
  output logic [ALC_HW_W-1:0] lk_hw_address,
  output logic [ALC_NET_W-1:0] lk_network_address,
  output logic lk_valid,
  // Input word stream
  input wire logic in_valid,
  input wire logic in_last,
  input wire logic [ALC_WORD_W-1:0] input_word_stream,
  output logic in_ready,
  // Output word stream
  output logic out_valid,
  output logic out_last,
  output logic [ALC_WORD_W-1:0] output_word_stream,
  input wire logic out_ready,
  // Captured header addresses
  output logic [ALC_HW_W-1:0] dest_hw_address,
  output logic [ALC_HW_W-1:0] source_hw_address,
  output logic hdr_done
);
  localparam int IW = (table_slot_count > 1) ? $clog2(table_slot_count) : 1;

  alc_address_pair_entry_s slot_array [table_slot_count];

  logic [table_slot_count-1:0] free_vec;
  logic [table_slot_count-1:0] clr_hit_vec;
  logic [table_slot_count-1:0] lk_hit_vec;
  logic free_any;
  logic clr_any;
  logic lk_any;
  logic [IW-1:0] free_idx;
  logic [IW-1:0] clr_idx;
  logic [IW-1:0] lk_idx;

  always_comb
  begin
    for (int i = 0; i < table_slot_count; i++)
    begin
      free_vec[i] = !slot_array[i].valid;
      clr_hit_vec[i] = slot_array[i].valid &&
                       (slot_array[i].network_address_field == removal_key);
      lk_hit_vec[i] = slot_array[i].valid &&
                      (slot_array[i].network_address_field == lookup_key);
    end
  end

  // Priority encoders pick the lowest index; scanning downward leaves the lowest hit.
  always_comb
  begin
    free_any = 1'b0;
    clr_any = 1'b0;
    lk_any = 1'b0;
    free_idx = '0;
    clr_idx = '0;
    lk_idx = '0;
    for (int i = table_slot_count - 1; i >= 0; i--)
    begin
      if (free_vec[i])
      begin
        free_any = 1'b1;
        free_idx = IW'(i);
      end
      if (clr_hit_vec[i])
      begin
        clr_any = 1'b1;
        clr_idx = IW'(i);
      end
      if (lk_hit_vec[i])
      begin
        lk_any = 1'b1;
        lk_idx = IW'(i);
      end
    end
  end

  // Slot updates. All decisions use the table as it stood before this edge.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < table_slot_count; i++)
      begin
        slot_array[i] <= '{hw_address: '0, network_address_field: '0,
                           valid: ALC_VALID_RESET};
      end
    end
    else
    begin
      if (clr_req && clr_any)
      begin
        slot_array[clr_idx].valid <= 1'b0;
      end
      if (wr_req && free_any)
      begin
        slot_array[free_idx] <= '{hw_address: wr_hw_address,
                                  network_address_field: wr_network_address,
                                  valid: 1'b1};
      end
    end
  end

  // Request answers, one cycle after the request.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_done <= 1'b0;
      wr_ok <= 1'b0;
      clr_done <= 1'b0;
      clr_ok <= 1'b0;
    end
    else
    begin
      wr_done <= wr_req;
      wr_ok <= wr_req && free_any;
      clr_done <= clr_req;
      clr_ok <= clr_req && clr_any;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lk_done <= 1'b0;
      lk_hw_address <= '0;
      lk_network_address <= '0;
      lk_valid <= 1'b0;
    end
    else
    begin
      lk_done <= lk_req;
      if (lk_req)
      begin
        if (lk_any)
        begin
          lk_hw_address <= slot_array[lk_idx].hw_address;
          lk_network_address <= slot_array[lk_idx].network_address_field;
          lk_valid <= 1'b1;
        end
        else
        begin
          lk_hw_address <= '0;
          lk_network_address <= '0;
          lk_valid <= 1'b0;
        end
      end
    end
  end

  // Word path: words enter a FIFO; header fields are taken as they are accepted.
  alc_fifo_if #(.W(ALC_WORD_W + 1)) fin ();
  alc_fifo_if #(.W(ALC_WORD_W + 1)) fout ();

  alc_fifo #(.W(ALC_WORD_W + 1), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .in_s(fin.snk),
    .out_s(fout.src)
  );

  logic in_take;
  alc_hdr_e hdr_q;

  assign fin.valid = in_valid;
  assign fin.data = {in_last, input_word_stream};
  assign in_ready = fin.ready;
  assign in_take = in_valid && fin.ready;

  assign out_valid = fout.valid;
  assign out_last = fout.data[ALC_WORD_W];
  assign output_word_stream = fout.data[ALC_WORD_W-1:0];
  assign fout.ready = out_ready;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hdr_q <= ALC_HDR_FIRST;
    end
    else if (in_take)
    begin
      unique case (hdr_q)
        ALC_HDR_FIRST:
          hdr_q <= in_last ? ALC_HDR_FIRST : ALC_HDR_SECOND;
        ALC_HDR_SECOND:
          hdr_q <= in_last ? ALC_HDR_FIRST : ALC_HDR_BODY;
        ALC_HDR_BODY:
          hdr_q <= in_last ? ALC_HDR_FIRST : ALC_HDR_BODY;
      endcase
    end
  end

  // Each header word is taken in its own cycle, so the stream is never read twice.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dest_hw_address <= '0;
      source_hw_address <= '0;
      hdr_done <= 1'b0;
    end
    else
    begin
      hdr_done <= 1'b0;
      if (in_take && hdr_q == ALC_HDR_FIRST)
      begin
        dest_hw_address <= input_word_stream[ALC_DST_POS +: ALC_HW_W];
        source_hw_address[15:0] <= input_word_stream[ALC_SRC_LO_POS +: 16];
      end
      if (in_take && hdr_q == ALC_HDR_SECOND)
      begin
        source_hw_address[47:16] <= input_word_stream[ALC_SRC_HI_POS +: 32];
        hdr_done <= 1'b1;
      end
    end
  end
endmodule

/* shared/alc_pkg.sv */
// Package holding constants and types of the address lookup table.
package alc_pkg;
  localparam int ALC_HW_W = 48;
  localparam int ALC_NET_W = 32;
  localparam int ALC_WORD_W = 64;
  localparam int ALC_SLOTS = 8;
  localparam int ALC_FIFO_DEPTH = 16;
  localparam int ALC_SRC_LO_POS = 48;
  localparam int ALC_SRC_HI_POS = 0;
  localparam int ALC_DST_POS = 0;
  localparam logic ALC_VALID_RESET = 1'b0;

  // One table slot.
  typedef struct packed {
    logic [ALC_HW_W-1:0] hw_address;
    logic [ALC_NET_W-1:0] network_address_field;
    logic valid;
  } alc_address_pair_entry_s;

  typedef enum logic [1:0] {
    ALC_HDR_FIRST,
    ALC_HDR_SECOND,
    ALC_HDR_BODY
  } alc_hdr_e;
endpackage

/* shared/alc_fifo_if.sv */
// Interface carrying one side of a ready/valid word stream.
interface alc_fifo_if #(parameter int W = 64);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* hw/alc_fifo.sv */
// Synchronous FIFO with ready/valid on both sides.
module alc_fifo #(
  parameter int W = 64,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Ports
  alc_fifo_if.snk in_s,
  alc_fifo_if.src out_s
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_s.ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_s.valid = (cnt_q != '0);
  assign out_s.data = mem_q[rd_q];
  assign push = in_s.valid && in_s.ready;
  assign pop = out_s.valid && out_s.ready;

  always_ff @(posedge clk_sys)
  begin
    if (push)
    begin
      mem_q[wr_q] <= in_s.data;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + AW'(1);
      end
      if (pop)
      begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + AW'(1);
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

/* bench/alc_lookup_cam_checker.sv */
// Checker watching the address lookup table ports.
module alc_lookup_cam_checker
  import alc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Table requests and answers
  input wire logic wr_req,
  input wire logic wr_done,
  input wire logic wr_ok,
  input wire logic clr_req,
  input wire logic clr_done,
  input wire logic clr_ok,
  input wire logic lk_req,
  input wire logic [ALC_NET_W-1:0] lookup_key,
  input wire logic lk_done,
  input wire logic [ALC_HW_W-1:0] lk_hw_address,
  input wire logic [ALC_NET_W-1:0] lk_network_address,
  input wire logic lk_valid,
  // Output stream
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic [ALC_WORD_W-1:0] output_word_stream
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  a_wr_done_next: assert property (wr_req |=> wr_done)
    else $error("write answer missing");
  a_wr_ok_done: assert property (wr_ok |-> wr_done)
    else $error("write ok without done");
  a_clr_answer: assert property (clr_done == $past(clr_req))
    else $error("clear answer timing wrong");
  a_clr_ok_done: assert property (clr_ok |-> clr_done)
    else $error("clear ok without done");
  a_lk_done_next: assert property (lk_req |=> lk_done)
    else $error("lookup answer missing");
  a_lk_hit_key: assert property (lk_req ##1 lk_valid |-> lk_network_address == $past(lookup_key))
    else $error("lookup hit has wrong key");
  a_lk_miss_zero: assert property (lk_done && !lk_valid |-> lk_hw_address == '0 && lk_network_address == '0)
    else $error("lookup miss not zero");
  a_lk_result_hold: assert property (!lk_req |=> $stable({lk_hw_address, lk_network_address, lk_valid}))
    else $error("lookup result changed");
  a_out_word_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(output_word_stream))
    else $error("stalled word not held");
endmodule

bind alc_lookup_cam alc_lookup_cam_checker chk_i (.clk_sys, .rst_n, .wr_req, .wr_done, .wr_ok,
  .clr_req, .clr_done, .clr_ok, .lk_req, .lookup_key, .lk_done, .lk_hw_address,
  .lk_network_address, .lk_valid, .out_valid, .out_ready, .output_word_stream);

/* bench/alc_sink_model.sv */
// Output stream sink that stalls at random, or fully while held off.
module alc_sink_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Handshake
  input wire logic hold,
  output logic out_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] lfsr_q;
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n) lfsr_q <= 8'h5b;
    else lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
  end
  assign out_ready = !hold && lfsr_q[0];
endmodule

/* bench/alc_lookup_cam_test.sv */
// Self-checking bench for the address lookup table.
module alc_lookup_cam_test
  import alc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0, rst_n = 1'b0, wr_req = 1'b0, clr_req = 1'b0, lk_req = 1'b0;
  logic in_valid = 1'b0, in_last = 1'b0, hold = 1'b1, out_ready;
  logic wr_done, wr_ok, clr_done, clr_ok, lk_done, lk_valid, in_ready, out_valid, out_last;
  logic hdr_done;
  logic [47:0] wr_hw = '0, lk_hw, dst, src;
  logic [47:0] hw[8];
  logic [31:0] wr_net = 0, rkey = 0, lkey = 0, lk_net, rng = 32'h8d2831f7;
  logic [63:0] in_word = '0, out_word, w0, w1;
  logic [64:0] sent[$];
  int n_fail = 0, samples_checked = 0, cycles = 0;

  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  task automatic chk(input bit c, input string m);
    samples_checked++;
    if (!c)
    begin
      n_fail++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask

  task automatic tally_and_finish();
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Kind 0 writes, 1 clears, 2 looks up; ok is the expected answer.
  task automatic op(input int k, input logic [31:0] a, input logic [47:0] h, input bit ok);
    @(posedge clk_sys);
    #5;
    wr_req = (k == 0);
    clr_req = (k == 1);
    lk_req = (k == 2);
    wr_net = a;
    rkey = a;
    lkey = a;
    wr_hw = h;
    @(posedge clk_sys);
    #5;
    {wr_req, clr_req, lk_req} = 3'h0;
    if (k == 0) chk(wr_done === 1'b1 && wr_ok === ok, "write result");
    if (k == 1) chk(clr_done === 1'b1 && clr_ok === ok, "clear result");
    if (k == 2) chk(lk_done === 1'b1 && lk_valid === ok && lk_hw === (ok ? h : 48'h0)
      && lk_net === (ok ? a : 32'h0), "lookup result");
  endtask

  alc_lookup_cam DUT (.clk_sys, .rst_n, .wr_req, .wr_hw_address(wr_hw),
    .wr_network_address(wr_net), .wr_done, .wr_ok, .clr_req, .removal_key(rkey), .clr_done,
    .clr_ok, .lk_req, .lookup_key(lkey), .lk_done, .lk_hw_address(lk_hw),
    .lk_network_address(lk_net), .lk_valid, .in_valid, .in_last, .input_word_stream(in_word),
    .in_ready, .out_valid, .out_last, .output_word_stream(out_word), .out_ready,
    .dest_hw_address(dst), .source_hw_address(src), .hdr_done);
  alc_sink_model SNK (.clk_sys, .rst_n, .hold, .out_ready);

  initial
  begin
    forever #25 clk_sys = ~clk_sys;
  end

  // Words are compared at the falling edge, clear of the launching edge.
  always @(negedge clk_sys)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_fail++;
      tally_and_finish();
    end
    else if (rst_n && out_valid === 1'b1 && out_ready === 1'b1)
    begin
      chk({out_last, out_word} === sent.pop_front(), "order");
    end
  end

  initial
  begin
    repeat (10) @(posedge clk_sys);
    #5 rst_n = 1;
    op(2, xs(), 48'h0, 0);
    for (int i = 0; i < 8; i++)
    begin
      hw[i] = {16'(i), xs()};
      op(0, 32'ha0 + i, hw[i], 1);
    end
    op(0, 32'hff, 48'h1, 0);
    for (int i = 0; i < 8; i++) op(2, 32'ha0 + i, hw[i], 1);
    op(1, 32'ha3, 48'h0, 1);
    op(1, 32'ha3, 48'h0, 0);
    op(0, 32'ha5, 48'h5a5a, 1);
    op(2, 32'ha5, 48'h5a5a, 1);
    op(1, 32'ha5, 48'h0, 1);
    op(2, 32'ha5, hw[5], 1);
    // All three requests at once: lookup misses on the old table, slot 3 takes the write.
    @(posedge clk_sys);
    #5;
    {wr_req, clr_req, lk_req} = 3'h7;
    wr_net = 32'hb0;
    wr_hw = 48'hb0b0;
    lkey = 32'hb0;
    rkey = 32'ha4;
    @(posedge clk_sys);
    #5;
    {wr_req, clr_req, lk_req} = 3'h0;
    chk(wr_done === 1'b1 && wr_ok === 1'b1 && clr_done === 1'b1 && clr_ok === 1'b1
      && lk_done === 1'b1 && lk_valid === 1'b0 && lk_net === 32'h0, "same cycle order");
    op(2, 32'hb0, 48'hb0b0, 1);
    op(0, 32'hb1, 48'hb1, 1);
    op(0, 32'hb2, 48'hb2, 0);
    op(2, 32'ha4, 48'h0, 0);
    @(posedge clk_sys);
    #5;
    for (int i = 0; i < 16; i++)
    begin
      in_valid = 1;
      in_last = (i == 15);
      in_word = {xs(), xs()};
      sent.push_back({in_last, in_word});
      if (i == 0) w0 = in_word;
      if (i == 1) w1 = in_word;
      chk(in_ready === 1'b1, "word refused early");
      chk(hdr_done === (i == 2), "header done pulse");
      @(posedge clk_sys);
      #5;
    end
    chk(in_ready === 1'b0, "full buffer not refused");
    in_valid = 0;
    chk(dst === w0[47:0] && src === {w1[31:0], w0[63:48]}, "header capture");
    hold = 0;
    for (int i = 0; i < 300 && sent.size() > 0; i++) @(posedge clk_sys);
    #5;
    chk(sent.size() == 0 && out_valid === 1'b0, "drain");
    tally_and_finish();
  end
endmodule
